/* File: pkg/bt_evt_if.sv */
`timescale 1ns/1ns
interface bt_evt_if;
    logic ext_pin;
    logic polarity;
    logic [bt_pkg::FLT_W-1:0] flt_sel;
    logic ext_edge;
    logic ext_level;
    logic tick_in;
    logic presc_load;
    logic [bt_pkg::PRS_W-1:0] presc_sel;
    logic div_tick;

    modport cond (
        input ext_pin,
        input polarity,
        input flt_sel,
        output ext_edge,
        output ext_level
    );

    modport presc (
        input tick_in,
        input presc_load,
        input presc_sel,
        output div_tick
    );

    modport core (
        output ext_pin,
        output polarity,
        output flt_sel,
        input ext_edge,
        input ext_level,
        output tick_in,
        output presc_load,
        output presc_sel,
        input div_tick
    );
endinterface

/* File: pkg/bt_pkg.sv */
package bt_pkg;

    localparam int CNT_W = 16;
    localparam int PRS_W = 4;
    localparam int DIV_W = 15;
    localparam int FLT_W = 3;
    localparam int FLT_CNT_W = 8;
    localparam int CSEL_W = 3;
    localparam int NUM_BASIC = 3;

    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_COUNTER = 2'h1;
    localparam logic [1:0] MODE_TRIGGER = 2'h2;
    localparam logic [1:0] MODE_GATED = 2'h3;

    localparam logic [CSEL_W-1:0] CSEL_BASIC0 = 3'h0;
    localparam logic [CSEL_W-1:0] CSEL_BASIC1 = 3'h1;
    localparam logic [CSEL_W-1:0] CSEL_BASIC2 = 3'h2;
    localparam logic [CSEL_W-1:0] CSEL_GENERAL = 3'h3;
    localparam logic [CSEL_W-1:0] CSEL_ADVANCED = 3'h7;

    localparam logic [CNT_W-1:0] RST_COUNTER = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;
    localparam logic [PRS_W-1:0] RST_PRS = 4'h0;
    localparam logic [DIV_W-1:0] RST_DIV = 15'h0000;
    localparam logic [DIV_W:0] DIV_ONE = 16'h0001;
    localparam logic [FLT_CNT_W-1:0] RST_FLT_CNT = 8'h00;
    localparam logic [FLT_CNT_W:0] FLT_ONE = 9'h001;

endpackage

/* File: src/bt_input_cond.sv */
`timescale 1ns/1ns
module bt_input_cond (
    input wire logic sys_clk,
    input wire logic arst_n,
    bt_evt_if.cond evt
);
    logic sync1_q;
    logic sync2_q;
    logic flt_q;
    logic act_q;
    logic [bt_pkg::FLT_CNT_W-1:0] flt_cnt_q;

    wire logic [bt_pkg::FLT_CNT_W:0] flt_thr_w;
    wire logic [bt_pkg::FLT_CNT_W:0] flt_next_w;
    wire logic flt_done_w;
    wire logic act_w;

    // Code 0 passes after one sample; code n needs 2**n stable samples
    assign flt_thr_w = bt_pkg::FLT_ONE << evt.flt_sel;
    assign flt_next_w = {1'b0, flt_cnt_q} + bt_pkg::FLT_ONE;
    assign flt_done_w = flt_next_w >= flt_thr_w;
    // Polarity flips both edge and level sense; changing it can fake an edge
    assign act_w = flt_q ^ evt.polarity;
    assign evt.ext_level = act_w;
    assign evt.ext_edge = act_w & ~act_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= evt.ext_pin;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flt_q <= 1'b0;
            flt_cnt_q <= bt_pkg::RST_FLT_CNT;
        end else if (sync2_q == flt_q) begin
            flt_cnt_q <= bt_pkg::RST_FLT_CNT;
        end else if (flt_done_w) begin
            flt_q <= sync2_q;
            flt_cnt_q <= bt_pkg::RST_FLT_CNT;
        end else begin
            flt_cnt_q <= flt_next_w[bt_pkg::FLT_CNT_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            act_q <= 1'b0;
        end else begin
            act_q <= act_w;
        end
    end
endmodule // bt_input_cond

/* File: src/bt_prescaler.sv */
`timescale 1ns/1ns
module bt_prescaler (
    input wire logic sys_clk,
    input wire logic arst_n,
    bt_evt_if.presc evt
);
    logic [bt_pkg::PRS_W-1:0] sel_q;
    logic [bt_pkg::DIV_W-1:0] div_q;

    wire logic [bt_pkg::DIV_W:0] mask_full_w;
    wire logic [bt_pkg::DIV_W-1:0] mask_w;
    wire logic hit_w;

    // Ratio is 2**sel, 1 up to 32768
    assign mask_full_w = (bt_pkg::DIV_ONE << sel_q) - bt_pkg::DIV_ONE;
    assign mask_w = mask_full_w[bt_pkg::DIV_W-1:0];
    assign hit_w = evt.tick_in & ((div_q & mask_w) == mask_w);
    assign evt.div_tick = hit_w;

    // New ratio only on overflow or enable rise, so a period is never torn
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_q <= bt_pkg::RST_PRS;
            div_q <= bt_pkg::RST_DIV;
        end else if (evt.presc_load) begin
            sel_q <= evt.presc_sel;
            div_q <= bt_pkg::RST_DIV;
        end else if (hit_w) begin
            div_q <= bt_pkg::RST_DIV;
        end else if (evt.tick_in) begin
            div_q <= div_q + bt_pkg::DIV_ONE[bt_pkg::DIV_W-1:0];
        end
    end
endmodule // bt_prescaler

/* File: src/bt_timer.sv */
// What this block does
// - Mode 0x01 counts prescaled events, not the peripheral clock.
// - Counter mode advances on each divided count clock pulse.
// - Source select 1 takes the cascade input, 0 the external pin.
// - External pin is filtered; polarity picks rising or falling edges.
// - Counter reaching reload value gives overflow pulse and overflow flag.
// - Overflow interrupt when enabled; flag cleared by software clear strobe.
// - Mode 0x02 starts counting prescaled clock on enable or trigger.
// - Trigger source chosen by source select, pin edge by polarity.
// - Trigger sets enable, sets trigger flag, counts from current value.
// - Clearing enable halts at once; enable or trigger resumes from hold.
// - Mode 0x03 counts prescaled clock while enabled and gate active.
// - Gate is always filtered pin; polarity picks high or low active.
// - Gated mode stops at once and resumes from held value.
// - Overflow pulse feeds cascades, forming 32 bits or any 1 to 65536 divide.
// - Later cascade stages count previous overflow or advanced master output.
// - Cascade codes 0-2 basic overflows, 3 general, 7 advanced master.
// - All basic timers share one external input from the dedicated pin.
// - Debug halt with freeze set stops the counter; otherwise counting goes on.
// - Prescaler divides by two to the select power, up to 32768.
// - Sixteen-bit up counter compared against sixteen-bit reload value.
// - Single run stops and clears enable after overflow; else wraps to zero.
// - Timer mode counts prescaled peripheral clock with no trigger or gate.
`timescale 1ns/1ns
module bt_timer (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [1:0] mode,
    input wire logic single_run_select,
    input wire logic count_source_select,
    input wire logic input_polarity,
    input wire logic [bt_pkg::FLT_W-1:0] ext_input_filter,
    input wire logic [bt_pkg::PRS_W-1:0] prescale_select,
    input wire logic [bt_pkg::CNT_W-1:0] reload_value,
    input wire logic enable_write,
    input wire logic enable_wdata,
    input wire logic counter_write,
    input wire logic [bt_pkg::CNT_W-1:0] counter_wdata,
    input wire logic overflow_irq_enable,
    input wire logic trigger_irq_enable,
    input wire logic overflow_flag_clear,
    input wire logic trigger_flag_clear,
    input wire logic [bt_pkg::CSEL_W-1:0] cascade_source_select,
    input wire logic [bt_pkg::NUM_BASIC-1:0] basic_overflow_in,
    input wire logic general_overflow_in,
    input wire logic advanced_master_in,
    input wire logic shared_event_pin,
    input wire logic debug_halt,
    input wire logic debug_freeze,
    output logic enable,
    output logic [bt_pkg::CNT_W-1:0] up_counter,
    output logic overflow_pulse,
    output logic overflow_flag,
    output logic trigger_flag,
    output logic running,
    output logic irq
);
    bt_evt_if evt ();

    bt_input_cond u_cond (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .evt(evt)
    );

    bt_prescaler u_presc (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .evt(evt)
    );

    logic enable_q;
    logic enable_d;
    logic [bt_pkg::CNT_W-1:0] counter_q;
    logic [bt_pkg::CNT_W-1:0] counter_d;
    logic ovp_q;
    logic ov_flag_q;
    logic ov_flag_d;
    logic tr_flag_q;
    logic tr_flag_d;
    logic running_q;
    logic irq_q;

    // Mode decode
    wire logic is_counter_w;
    wire logic is_trigger_w;
    wire logic is_gated_w;

    assign is_counter_w = (mode == bt_pkg::MODE_COUNTER);
    assign is_trigger_w = (mode == bt_pkg::MODE_TRIGGER);
    assign is_gated_w = (mode == bt_pkg::MODE_GATED);

    // Shared pin into the conditioning path
    assign evt.ext_pin = shared_event_pin;
    assign evt.polarity = input_polarity;
    assign evt.flt_sel = ext_input_filter;

    // Cascade source; unlisted codes give no events.
    // Own overflow is not blocked: a self loop is a software fault.
    wire logic sel_b0_w;
    wire logic sel_b1_w;
    wire logic sel_b2_w;
    wire logic sel_gen_w;
    wire logic sel_adv_w;
    wire logic cascade_evt_w;

    assign sel_b0_w = (cascade_source_select == bt_pkg::CSEL_BASIC0);
    assign sel_b1_w = (cascade_source_select == bt_pkg::CSEL_BASIC1);
    assign sel_b2_w = (cascade_source_select == bt_pkg::CSEL_BASIC2);
    assign sel_gen_w = (cascade_source_select == bt_pkg::CSEL_GENERAL);
    assign sel_adv_w = (cascade_source_select == bt_pkg::CSEL_ADVANCED);
    assign cascade_evt_w = (sel_b0_w & basic_overflow_in[0])
        | (sel_b1_w & basic_overflow_in[1])
        | (sel_b2_w & basic_overflow_in[2])
        | (sel_gen_w & general_overflow_in)
        | (sel_adv_w & advanced_master_in);

    // Event source for counting and triggering
    wire logic src_evt_w;

    assign src_evt_w = count_source_select ? cascade_evt_w : evt.ext_edge;

    // Trigger is a single-cycle pulse, so one edge starts once
    wire logic trigger_w;

    assign trigger_w = is_trigger_w & src_evt_w;

    // Run qualification
    wire logic frozen_w;
    wire logic gate_ok_w;
    wire logic stop_w;
    wire logic run_w;

    assign frozen_w = debug_halt & debug_freeze;
    assign gate_ok_w = ~is_gated_w | evt.ext_level;
    // Single run: block the tick in the cycle the flag sets and enable drops
    assign stop_w = ovp_q & single_run_select;
    assign run_w = enable_q & ~frozen_w & gate_ok_w & ~stop_w;

    // Counter mode counts events; the other modes count every clock
    assign evt.tick_in = run_w & (is_counter_w ? src_evt_w : 1'b1);

    // Compare against reload value
    wire logic at_reload_w;
    wire logic past_reload_w;
    wire logic ov_hit_w;

    assign at_reload_w = (counter_q == reload_value);
    // Reload lowered below the count: restart from zero with no overflow
    assign past_reload_w = (counter_q > reload_value);
    assign ov_hit_w = evt.div_tick & at_reload_w;

    // Prescaler ratio reloads on overflow or enable rise
    wire logic en_rise_w;

    assign en_rise_w = enable_d & ~enable_q;
    assign evt.presc_load = en_rise_w | ov_hit_w;
    assign evt.presc_sel = prescale_select;

    always_comb begin
        counter_d = counter_q;
        if (counter_write) begin
            counter_d = counter_wdata;
        end else if (evt.div_tick) begin
            if (at_reload_w | past_reload_w) begin
                counter_d = bt_pkg::RST_COUNTER;
            end else begin
                counter_d = counter_q + bt_pkg::CNT_STEP;
            end
        end
    end

    // Trigger wins over a write and over the single-run stop
    always_comb begin
        enable_d = enable_q;
        if (stop_w) begin
            enable_d = 1'b0;
        end
        if (enable_write) begin
            enable_d = enable_wdata;
        end
        if (trigger_w) begin
            enable_d = 1'b1;
        end
    end

    // Set beats clear in the same cycle
    always_comb begin
        ov_flag_d = ovp_q | (ov_flag_q & ~overflow_flag_clear);
        tr_flag_d = trigger_w | (tr_flag_q & ~trigger_flag_clear);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            counter_q <= bt_pkg::RST_COUNTER;
            enable_q <= 1'b0;
        end else begin
            counter_q <= counter_d;
            enable_q <= enable_d;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ovp_q <= 1'b0;
            running_q <= 1'b0;
        end else begin
            ovp_q <= ov_hit_w;
            running_q <= run_w;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ov_flag_q <= 1'b0;
            tr_flag_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ov_flag_q <= ov_flag_d;
            tr_flag_q <= tr_flag_d;
            irq_q <= (ov_flag_d & overflow_irq_enable)
                | (tr_flag_d & trigger_irq_enable);
        end
    end

    assign enable = enable_q;
    assign up_counter = counter_q;
    assign overflow_pulse = ovp_q;
    assign overflow_flag = ov_flag_q;
    assign trigger_flag = tr_flag_q;
    assign running = running_q;
    assign irq = irq_q;
endmodule // bt_timer

/* File: verif/bt_partner.sv */
`timescale 1ns/1ns
module bt_partner (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic pin_level,
    input wire logic fire,
    input wire logic [2:0] fire_sel,
    output logic shared_event_pin,
    output logic [bt_pkg::NUM_BASIC-1:0] basic_overflow_in,
    output logic general_overflow_in,
    output logic advanced_master_in
);
    // Pin is asynchronous, so skew it off the clock edge
    assign #1 shared_event_pin = pin_level;
    // Neighbours only; this timer's own overflow is never looped back
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            basic_overflow_in <= 3'h0;
            general_overflow_in <= 1'b0;
            advanced_master_in <= 1'b0;
        end else begin
            basic_overflow_in <= {3{fire}} & (3'h1 << fire_sel);
            general_overflow_in <= fire && fire_sel == 3'h3;
            advanced_master_in <= fire && fire_sel == 3'h4;
        end
    end
endmodule // bt_partner

/* File: verif/bt_timer_assertions.sv */
`timescale 1ns/1ns
module bt_timer_assertions (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic single_run_select,
    input wire logic overflow_irq_enable,
    input wire logic trigger_irq_enable,
    input wire logic overflow_flag_clear,
    input wire logic counter_write,
    input wire logic debug_halt,
    input wire logic debug_freeze,
    input wire logic enable,
    input wire logic [bt_pkg::CNT_W-1:0] up_counter,
    input wire logic overflow_pulse,
    input wire logic overflow_flag,
    input wire logic trigger_flag,
    input wire logic running,
    input wire logic irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // A software load may land on the wrap cycle
    sequence wrap_s;
        overflow_pulse && !$past(counter_write);
    endsequence
    sequence stop_s;
        !enable ##1 (!running && up_counter == 16'h0000)[*2];
    endsequence
    ovf_wrap_a: assert property (wrap_s |-> up_counter == 16'h0000)
        else $error("counter not zero with overflow pulse");
    ovf_flag_a: assert property (overflow_pulse |=> overflow_flag)
        else $error("overflow flag not set after pulse");
    single_stop_a: assert property (single_run_select && overflow_pulse |=> stop_s)
        else $error("single run did not stop");
    irq_set_a: assert property (overflow_flag && $past(overflow_irq_enable) |-> irq)
        else $error("irq missing with flag enabled");
    irq_quiet_a: assert property (!(overflow_flag && $past(overflow_irq_enable))
        && !(trigger_flag && $past(trigger_irq_enable)) |-> !irq)
        else $error("irq without enabled flag");
    flag_clr_a: assert property (overflow_flag_clear && !overflow_pulse |=> !overflow_flag)
        else $error("overflow flag not cleared");
    freeze_a: assert property (debug_halt && debug_freeze |=> !running)
        else $error("counting while frozen");
    halt_a: assert property (!enable |=> !running)
        else $error("counting while disabled");
    trig_en_a: assert property ($rose(trigger_flag) |-> enable)
        else $error("trigger did not set enable");
    step_a: assert property (up_counter != $past(up_counter) && !$past(counter_write)
        |-> up_counter == $past(up_counter) + 16'h0001 || up_counter == 16'h0000)
        else $error("counter moved by more than one");
endmodule // bt_timer_assertions

/* File: verif/bt_timer_bench.sv */
`timescale 1ns/1ns
module bt_timer_bench;
    logic sys_clk = 1'b0, arst_n = 1'b0, single_run_select = 1'b0;
    logic [1:0] mode = 2'h0;
    logic count_source_select = 1'b0, input_polarity = 1'b0, pin_level = 1'b0;
    logic [2:0] ext_input_filter = 3'h0, cascade_source_select = 3'h0, fire_sel = 3'h0;
    logic [3:0] prescale_select = 4'h0;
    logic [15:0] reload_value = 16'hffff, counter_wdata = 16'h0000, h;
    logic enable_write = 1'b0, enable_wdata = 1'b0, counter_write = 1'b0, fire = 1'b0;
    logic overflow_irq_enable = 1'b0, trigger_irq_enable = 1'b0, overflow_flag_clear = 1'b0;
    logic trigger_flag_clear = 1'b0, debug_halt = 1'b0, debug_freeze = 1'b0;
    logic [2:0] basic_overflow_in;
    logic general_overflow_in, advanced_master_in, shared_event_pin;
    logic enable, overflow_pulse, overflow_flag, trigger_flag, running, irq;
    logic [15:0] up_counter;
    int n_fail = 0, checked = 0, n;
    bt_timer u_bt_timer (
        .sys_clk, .arst_n, .mode, .single_run_select, .count_source_select, .input_polarity,
        .ext_input_filter, .prescale_select, .reload_value, .enable_write, .enable_wdata,
        .counter_write, .counter_wdata, .overflow_irq_enable, .trigger_irq_enable,
        .overflow_flag_clear, .trigger_flag_clear, .cascade_source_select, .basic_overflow_in,
        .general_overflow_in, .advanced_master_in, .shared_event_pin, .debug_halt,
        .debug_freeze, .enable, .up_counter, .overflow_pulse, .overflow_flag, .trigger_flag,
        .running, .irq
    );
    bt_partner u_bt_partner (
        .sys_clk, .arst_n, .pin_level, .fire, .fire_sel, .shared_event_pin,
        .basic_overflow_in, .general_overflow_in, .advanced_master_in
    );
    always #2 sys_clk = ~sys_clk;
    task tally_and_finish();
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(string nm, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Kinds: 0 enable write, 1 counter load, 2 overflow clear, 3 trigger clear
    task ctl(int k, logic [15:0] v);
        enable_wdata <= v[0];
        counter_wdata <= v;
        enable_write <= (k == 0);
        counter_write <= (k == 1);
        overflow_flag_clear <= (k == 2);
        trigger_flag_clear <= (k == 3);
        @(posedge sys_clk);
        {enable_write, counter_write, overflow_flag_clear, trigger_flag_clear} <= 4'h0;
        @(posedge sys_clk);
    endtask
    task pulse(int k);
        fire_sel <= k[2:0];
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    // Long tail covers sync, filter and edge latency
    task pin_pulse(int w);
        pin_level <= ~pin_level;
        repeat (w) @(posedge sys_clk);
        pin_level <= ~pin_level;
        repeat (16) @(posedge sys_clk);
    endtask
    task wait_ovf(output int c);
        c = 0;
        do begin
            @(negedge sys_clk);
            c++;
        end while (overflow_pulse !== 1'b1 && c < 3000);
        chk("wrap", 16'h0000, up_counter);
        @(posedge sys_clk);
    endtask
    task hold(string nm, logic mv);
        logic [15:0] c;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        c = up_counter;
        repeat (8) @(negedge sys_clk);
        chk(nm, {15'h0, mv}, {15'h0, up_counter !== c});
        @(posedge sys_clk);
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(negedge sys_clk);
        chk("reset", 16'h0000, up_counter | {enable, overflow_flag, trigger_flag, irq});
        @(posedge sys_clk);
        reload_value <= 16'h0002;
        overflow_irq_enable <= 1'b1;
        for (int p = 0; p < 4; p = p * 2 + 1) begin
            ctl(0, 0);
            prescale_select <= p[3:0];
            ctl(1, 0);
            ctl(0, 1);
            wait_ovf(n);
            wait_ovf(n);
            chk("period", 16'(3 << p), 16'(n));
        end
        chk("flag irq", 16'h0003, {14'h0, overflow_flag, irq});
        ctl(0, 0);
        ctl(2, 0);
        @(negedge sys_clk);
        chk("flag clear", 16'h0000, {14'h0, overflow_flag, irq});
        @(posedge sys_clk);
        overflow_irq_enable <= 1'b0;
        prescale_select <= 4'h0;
        single_run_select <= 1'b1;
        reload_value <= 16'h0003;
        ctl(1, 0);
        ctl(0, 1);
        wait_ovf(n);
        repeat (4) @(negedge sys_clk);
        chk("single run", 16'h0000, up_counter | {15'h0, enable});
        @(posedge sys_clk);
        single_run_select <= 1'b0;
        reload_value <= 16'hffff;
        ctl(0, 1);
        debug_halt <= 1'b1;
        debug_freeze <= 1'b1;
        hold("frozen", 1'b0);
        debug_freeze <= 1'b0;
        hold("not frozen", 1'b1);
        // Reload lowered under the count: wrap to zero, no overflow
        ctl(2, 0);
        reload_value <= 16'h0008;
        repeat (3) @(negedge sys_clk);
        chk("low reload", 16'h0000, {15'h0, overflow_flag | (up_counter > 16'h0004)});
        @(posedge sys_clk);
        reload_value <= 16'hffff;
        debug_halt <= 1'b0;
        mode <= bt_pkg::MODE_COUNTER;
        count_source_select <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            cascade_source_select <= c[2:0];
            ctl(1, 0);
            for (int k = 0; k < 5; k++) pulse(k);
            @(negedge sys_clk);
            chk("cascade", {15'h0, c < 4 || c == 7}, up_counter);
            @(posedge sys_clk);
        end
        count_source_select <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            ctl(0, 0);
            input_polarity <= p[0];
            ext_input_filter <= p ? 3'h2 : 3'h0;
            pin_level <= p[0];
            repeat (12) @(posedge sys_clk);
            ctl(1, 0);
            ctl(0, 1);
            for (int w = 0; w < 4; w++) pin_pulse(w < 3 ? 10 : 2);
            @(negedge sys_clk);
            chk("pin edges", p ? 16'h0003 : 16'h0004, up_counter);
            @(posedge sys_clk);
        end
        ctl(0, 0);
        count_source_select <= 1'b1;
        cascade_source_select <= bt_pkg::CSEL_GENERAL;
        trigger_irq_enable <= 1'b1;
        mode <= bt_pkg::MODE_TRIGGER;
        ctl(1, 16'h0005);
        hold("no start", 1'b0);
        pulse(3);
        @(negedge sys_clk);
        chk("trigger", 16'h0007, {13'h0, enable, trigger_flag, irq});
        chk("from five", 16'h0001, {15'h0, up_counter > 5 && up_counter < 10});
        @(posedge sys_clk);
        ctl(0, 0);
        hold("trig halt", 1'b0);
        h = up_counter;
        count_source_select <= 1'b0;
        pin_pulse(10);
        @(negedge sys_clk);
        chk("resume", 16'h0001, {15'h0, enable && up_counter > h && up_counter < h + 40});
        @(posedge sys_clk);
        ctl(3, 0);
        @(negedge sys_clk);
        chk("trig clear", 16'h0000, {14'h0, trigger_flag, irq});
        @(posedge sys_clk);
        mode <= bt_pkg::MODE_GATED;
        ext_input_filter <= 3'h0;
        for (int p = 0; p < 2; p++) begin
            input_polarity <= p[0];
            pin_level <= p[0];
            ctl(0, 1);
            hold("gate shut", 1'b0);
            pin_level <= ~p[0];
            hold("gate open", 1'b1);
            ctl(0, 0);
            hold("gate no enable", 1'b0);
        end
        tally_and_finish();
    end
endmodule // bt_timer_bench
bind bt_timer bt_timer_assertions u_chk (
    .sys_clk, .arst_n, .single_run_select, .overflow_irq_enable, .trigger_irq_enable,
    .overflow_flag_clear, .counter_write, .debug_halt, .debug_freeze, .enable, .up_counter,
    .overflow_pulse, .overflow_flag, .trigger_flag, .running, .irq
);
